// ---- iap_flash_write_buffer_ctrl.sv ----
// Notes on behaviour
// - setting buffer wipe clears the whole buffer, then hardware drops the bit.
// - 32-word buffer is one page, selected by address bits 13..5.
// - writing data word0 high loads the combined 16-bit word at current address.
// - each such load increments the address and writes it back.
// - at low address bits 11111b the address stops incrementing.
// - buffer is cleared automatically when a flash write finishes.
// - writing data word0 low only updates that register.
// - unlocked bit set by hardware only; software may clear it, disabling updates.
// - operation select 000 write, 001 page erase, 011 read, 110 unlock.
// - unlock trigger starts a timer; hardware clears the trigger on expiry.
// - program go starts the selected write or erase, cleared on completion.
// - reads run only while read permit is high.
// - read go starts a flash read, cleared on completion.
// - cpu is stalled while a started operation is in progress.
// - writing 55h into the chip reset key resets the whole chip.
// - timing select 0 gives 3.2/2.2 ms, 1 gives 3.7/3.0 ms erase/write.
// - unimplemented bits of buffer control and address high read zero.
// - key 00,0d,c3 low then 04,09,40 high; wrong key keeps updates locked.
// - in erase mode each data word0 high write tags the address and advances.
`timescale 1ns/1ps
`default_nettype none
`include "iap_params.svh"
module iap_flash_write_buffer_ctrl #(
  parameter int unsigned ERASE0_CYC = `IAP_T_ERASE0_US * `IAP_CYC_PER_US,
  parameter int unsigned WRITE0_CYC = `IAP_T_WRITE0_US * `IAP_CYC_PER_US,
  parameter int unsigned ERASE1_CYC = `IAP_T_ERASE1_US * `IAP_CYC_PER_US,
  parameter int unsigned WRITE1_CYC = `IAP_T_WRITE1_US * `IAP_CYC_PER_US,
  parameter int unsigned UNLOCK_CYC = `IAP_T_UNLOCK_US * `IAP_CYC_PER_US
) (
  input wire logic i_mclk,
  input wire logic i_sys_rst,
  input wire iap_pkg::sfr_req_s i_sfr,
  input wire logic [3:0] i_sfr_ridx,
  input wire logic [15:0] i_flash_rdata,
  output logic [7:0] o_sfr_rdata,
  output logic o_cpu_stall,
  output logic o_chip_reset,
  output iap_pkg::flash_cmd_s o_flash_cmd,
  output logic o_flash_busy
);
  localparam int unsigned READ_CYC = `IAP_T_READ_CYC;

  logic [7:0] ctrl_ff, nxt_ctrl;
  logic [7:0] rkey_ff;
  logic [1:0] btim_ff, nxt_btim;
  logic [13:0] addr_ff, nxt_addr;
  logic [7:0] d_lo_ff [0:3];
  logic [7:0] d_hi_ff [0:3];
  logic [15:0] buf_ff [0:31];
  logic [31:0] tag_ff;
  logic [22:0] op_cnt_ff;
  logic [15:0] ulk_cnt_ff;
  logic [4:0] pidx_ff;
  iap_pkg::seq_state_e st_ff, nxt_st;
  logic [7:0] rdata_ff;
  logic stall_ff, crst_ff, busy_ff;
  iap_pkg::flash_cmd_s cmd_ff;

  // register port decode
  wire wr = i_sfr.we;
  wire wr_ctrl = wr && i_sfr.idx == `IAP_IDX_OP_CTRL;
  wire wr_rkey = wr && i_sfr.idx == `IAP_IDX_RST_KEY;
  wire wr_btim = wr && i_sfr.idx == `IAP_IDX_BUF_TIM;
  wire wr_alo = wr && i_sfr.idx == `IAP_IDX_ADDR_LO;
  wire wr_ahi = wr && i_sfr.idx == `IAP_IDX_ADDR_HI;
  wire wr_d0h = wr && i_sfr.idx == `IAP_IDX_D0_HI;
  wire [2:0] op_sel = ctrl_ff[`IAP_B_OPSEL_HI:`IAP_B_OPSEL_LO];
  wire unlocked = ctrl_ff[`IAP_B_UNLOCKED];
  wire is_write = op_sel == iap_pkg::OP_WRITE;
  wire is_erase = op_sel == iap_pkg::OP_ERASE;
  wire is_read = op_sel == iap_pkg::OP_READ;
  wire is_unlock = op_sel == iap_pkg::OP_UNLOCK;
  wire at_last = addr_ff[4:0] == `IAP_PAGE_LAST;
  wire load_word = wr_d0h && unlocked && (is_write || is_erase) && st_ff == iap_pkg::ST_IDLE;
  wire key_ok = d_lo_ff[1] == `IAP_KEY_D1L && d_lo_ff[2] == `IAP_KEY_D2L && d_lo_ff[3] == `IAP_KEY_D3L &&
                d_hi_ff[1] == `IAP_KEY_D1H && d_hi_ff[2] == `IAP_KEY_D2H && d_hi_ff[3] == `IAP_KEY_D3H;
  wire trig_on = ctrl_ff[`IAP_B_TRIGGER];
  wire ulk_done = trig_on && ulk_cnt_ff == 16'(UNLOCK_CYC - 1);
  wire [22:0] prog_len = btim_ff[`IAP_B_TIMING] ? (is_erase ? 23'(ERASE1_CYC) : 23'(WRITE1_CYC))
                                                : (is_erase ? 23'(ERASE0_CYC) : 23'(WRITE0_CYC));
  wire prog_start = ctrl_ff[`IAP_B_PROG_GO] && st_ff == iap_pkg::ST_IDLE && unlocked && (is_write || is_erase);
  wire read_start = ctrl_ff[`IAP_B_RD_GO] && st_ff == iap_pkg::ST_IDLE && ctrl_ff[`IAP_B_RD_PERMIT] && is_read;
  wire prog_end = st_ff == iap_pkg::ST_PROG && op_cnt_ff == prog_len - 23'h1;
  wire read_end = st_ff == iap_pkg::ST_READ && op_cnt_ff == 23'(READ_CYC - 1);
  wire wipe_end = st_ff == iap_pkg::ST_WIPE && pidx_ff == `IAP_PAGE_LAST;

  // sequencer next state
  always_comb begin
    nxt_st = st_ff;
    case (st_ff)
      iap_pkg::ST_IDLE: begin
        if (btim_ff[`IAP_B_WIPE]) begin
          nxt_st = iap_pkg::ST_WIPE;
        end else if (prog_start) begin
          nxt_st = iap_pkg::ST_PROG;
        end else if (read_start) begin
          nxt_st = iap_pkg::ST_READ;
        end
      end
      iap_pkg::ST_WIPE: if (wipe_end) nxt_st = iap_pkg::ST_IDLE;
      iap_pkg::ST_PROG: if (prog_end) nxt_st = iap_pkg::ST_WIPE;
      iap_pkg::ST_READ: if (read_end) nxt_st = iap_pkg::ST_IDLE;
      default: nxt_st = iap_pkg::ST_IDLE;
    endcase
  end

  // control register: software writes, hardware sets and clears
  always_comb begin
    nxt_ctrl = ctrl_ff;
    if (wr_ctrl) begin
      nxt_ctrl = i_sfr.wdata;
      nxt_ctrl[`IAP_B_UNLOCKED] = unlocked & i_sfr.wdata[`IAP_B_UNLOCKED];
      if (!i_sfr.wdata[`IAP_B_TRIGGER]) nxt_ctrl[`IAP_B_TRIGGER] = trig_on;
      if (!i_sfr.wdata[`IAP_B_PROG_GO]) nxt_ctrl[`IAP_B_PROG_GO] = ctrl_ff[`IAP_B_PROG_GO];
      if (!i_sfr.wdata[`IAP_B_RD_GO]) nxt_ctrl[`IAP_B_RD_GO] = ctrl_ff[`IAP_B_RD_GO];
      if (!is_unlock && i_sfr.wdata[`IAP_B_OPSEL_HI:`IAP_B_OPSEL_LO] != iap_pkg::OP_UNLOCK)
        nxt_ctrl[`IAP_B_TRIGGER] = trig_on;
    end
    if (ulk_done) begin
      nxt_ctrl[`IAP_B_TRIGGER] = 1'b0;
      if (key_ok && is_unlock) nxt_ctrl[`IAP_B_UNLOCKED] = 1'b1;
    end
    if (prog_end) nxt_ctrl[`IAP_B_PROG_GO] = 1'b0;
    if (read_end) nxt_ctrl[`IAP_B_RD_GO] = 1'b0;
    // a go bit that cannot start is dropped so the cpu is not left waiting
    if (ctrl_ff[`IAP_B_PROG_GO] && st_ff == iap_pkg::ST_IDLE && !prog_start && !btim_ff[`IAP_B_WIPE])
      nxt_ctrl[`IAP_B_PROG_GO] = 1'b0;
    if (ctrl_ff[`IAP_B_RD_GO] && st_ff == iap_pkg::ST_IDLE && !read_start && !prog_start && !btim_ff[`IAP_B_WIPE])
      nxt_ctrl[`IAP_B_RD_GO] = 1'b0;
  end

  // buffer control: wipe bit held until the clear sweep ends
  always_comb begin
    nxt_btim = btim_ff;
    if (wr_btim) nxt_btim = i_sfr.wdata[1:0] | {1'b0, btim_ff[`IAP_B_WIPE]};
    if (wipe_end) nxt_btim[`IAP_B_WIPE] = 1'b0;
  end

  // address: software write, else auto increment on word load
  always_comb begin
    nxt_addr = addr_ff;
    if (wr_alo) nxt_addr[7:0] = i_sfr.wdata;
    if (wr_ahi) nxt_addr[13:8] = i_sfr.wdata[5:0];
    if (load_word && !at_last) nxt_addr = addr_ff + 14'h1;
  end

  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      ctrl_ff <= `IAP_RESET_BYTE;
      btim_ff <= 2'h0;
      addr_ff <= 14'h0;
      st_ff <= iap_pkg::ST_IDLE;
    end else begin
      ctrl_ff <= nxt_ctrl;
      btim_ff <= nxt_btim;
      addr_ff <= nxt_addr;
      st_ff <= nxt_st;
    end
  end

  // data pairs; pair zero also takes the read result
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      for (int i = 0; i < 4; i++) begin
        d_lo_ff[i] <= `IAP_RESET_BYTE;
        d_hi_ff[i] <= `IAP_RESET_BYTE;
      end
    end else begin
      for (int i = 0; i < 4; i++) begin
        if (wr && i_sfr.idx == 4'(`IAP_IDX_D0_LO + 2 * i)) d_lo_ff[i] <= i_sfr.wdata;
        if (wr && i_sfr.idx == 4'(`IAP_IDX_D0_HI + 2 * i)) d_hi_ff[i] <= i_sfr.wdata;
      end
      if (read_end) begin
        d_lo_ff[0] <= i_flash_rdata[7:0];
        d_hi_ff[0] <= i_flash_rdata[15:8];
      end
    end
  end

  // page buffer and erase tags, one word cleared per cycle
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      tag_ff <= 32'h0;
      pidx_ff <= 5'h0;
    end else begin
      if (st_ff == iap_pkg::ST_WIPE) begin
        buf_ff[pidx_ff] <= 16'h0;
        tag_ff[pidx_ff] <= 1'b0;
        pidx_ff <= pidx_ff + 5'h1;
      end else begin
        pidx_ff <= 5'h0;
        if (load_word) begin
          buf_ff[addr_ff[4:0]] <= {i_sfr.wdata, d_lo_ff[0]};
          tag_ff[addr_ff[4:0]] <= is_erase;
        end
      end
    end
  end

  // timers for the unlock window and the flash operation
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      ulk_cnt_ff <= 16'h0;
      op_cnt_ff <= 23'h0;
    end else begin
      ulk_cnt_ff <= (trig_on && !ulk_done) ? ulk_cnt_ff + 16'h1 : 16'h0;
      op_cnt_ff <= (st_ff == iap_pkg::ST_PROG || st_ff == iap_pkg::ST_READ) && !prog_end && !read_end
                   ? op_cnt_ff + 23'h1 : 23'h0;
    end
  end

  // read mux, reserved bits zero
  wire [7:0] rd_mux =
    i_sfr_ridx == `IAP_IDX_OP_CTRL ? ctrl_ff :
    i_sfr_ridx == `IAP_IDX_RST_KEY ? rkey_ff :
    i_sfr_ridx == `IAP_IDX_BUF_TIM ? {6'h0, btim_ff} :
    i_sfr_ridx == `IAP_IDX_ADDR_LO ? addr_ff[7:0] :
    i_sfr_ridx == `IAP_IDX_ADDR_HI ? ({2'h0, addr_ff[13:8]} & `IAP_ADDR_HI_MASK) :
    i_sfr_ridx >= `IAP_IDX_D0_LO && i_sfr_ridx <= `IAP_IDX_D3_HI ?
      (i_sfr_ridx[0] ? d_lo_ff[2'((i_sfr_ridx - `IAP_IDX_D0_LO) >> 1)]
                     : d_hi_ff[2'((i_sfr_ridx - `IAP_IDX_D0_HI) >> 1)]) : 8'h00;

  // registered outputs; the flash command word mirrors the running operation
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      rkey_ff <= `IAP_RESET_BYTE;
      rdata_ff <= 8'h00;
      stall_ff <= 1'b0;
      crst_ff <= 1'b0;
      busy_ff <= 1'b0;
      cmd_ff <= '0;
    end else begin
      if (wr_rkey) rkey_ff <= i_sfr.wdata;
      crst_ff <= wr_rkey && i_sfr.wdata == `IAP_CHIP_RST_KEY;
      rdata_ff <= rd_mux;
      stall_ff <= nxt_st == iap_pkg::ST_PROG || nxt_st == iap_pkg::ST_READ;
      busy_ff <= nxt_st != iap_pkg::ST_IDLE;
      cmd_ff.addr <= addr_ff;
      cmd_ff.data <= buf_ff[addr_ff[4:0]];
      cmd_ff.we <= nxt_st == iap_pkg::ST_PROG && is_write;
      cmd_ff.erase <= nxt_st == iap_pkg::ST_PROG && is_erase;
    end
  end

  assign o_sfr_rdata = rdata_ff;
  assign o_cpu_stall = stall_ff;
  assign o_chip_reset = crst_ff;
  assign o_flash_cmd = cmd_ff;
  assign o_flash_busy = busy_ff;

  a_wipe_clears: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
    $rose(st_ff == iap_pkg::ST_WIPE) |-> ##[31:32] !btim_ff[`IAP_B_WIPE]) else $error("wipe did not end");
  a_addr_incr: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
    load_word && !at_last && !wr_alo && !wr_ahi |=> addr_ff == $past(addr_ff) + 14'h1) else $error("no incr");
  a_page_stop: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
    load_word && at_last |=> addr_ff == $past(addr_ff)) else $error("address passed page end");
  a_unlock_sw: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
    !unlocked && !ulk_done |=> !unlocked) else $error("unlocked set without key");
  a_trig_end: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
    ulk_done |=> !trig_on) else $error("trigger not cleared");
  a_stall_prog: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
    st_ff == iap_pkg::ST_PROG |-> o_cpu_stall) else $error("cpu not stalled");
  a_read_gate: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
    st_ff == iap_pkg::ST_IDLE && !ctrl_ff[`IAP_B_RD_PERMIT] |=> st_ff != iap_pkg::ST_READ) else $error("read w/o permit");
  a_chip_rst: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
    wr_rkey && i_sfr.wdata == `IAP_CHIP_RST_KEY |=> o_chip_reset) else $error("no chip reset");
  a_prog_wipe: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
    prog_end |=> st_ff == iap_pkg::ST_WIPE) else $error("buffer not cleared after write");
endmodule
`default_nettype wire

// ---- iap_params.svh ----
`ifndef IAP_PARAMS_SVH
`define IAP_PARAMS_SVH
// register indices on the special function register port
`define IAP_IDX_OP_CTRL 4'h0
`define IAP_IDX_RST_KEY 4'h1
`define IAP_IDX_BUF_TIM 4'h2
`define IAP_IDX_ADDR_LO 4'h3
`define IAP_IDX_ADDR_HI 4'h4
`define IAP_IDX_D0_LO 4'h5
`define IAP_IDX_D0_HI 4'h6
`define IAP_IDX_D1_LO 4'h7
`define IAP_IDX_D1_HI 4'h8
`define IAP_IDX_D2_LO 4'h9
`define IAP_IDX_D2_HI 4'ha
`define IAP_IDX_D3_LO 4'hb
`define IAP_IDX_D3_HI 4'hc
// field positions
`define IAP_B_UNLOCKED 7
`define IAP_B_OPSEL_HI 6
`define IAP_B_OPSEL_LO 4
`define IAP_B_TRIGGER 3
`define IAP_B_PROG_GO 2
`define IAP_B_RD_PERMIT 1
`define IAP_B_RD_GO 0
`define IAP_B_TIMING 1
`define IAP_B_WIPE 0
`define IAP_RESET_BYTE 8'h00
`define IAP_ADDR_HI_MASK 8'h3f
`define IAP_PAGE_LAST 5'h1f
`define IAP_CHIP_RST_KEY 8'h55
// unlock key, data pairs one to three low then high
`define IAP_KEY_D1L 8'h00
`define IAP_KEY_D2L 8'h0d
`define IAP_KEY_D3L 8'hc3
`define IAP_KEY_D1H 8'h04
`define IAP_KEY_D2H 8'h09
`define IAP_KEY_D3H 8'h40
// timing in microseconds at 200 MHz (200 cycles per us)
`define IAP_CYC_PER_US 200
`define IAP_T_ERASE0_US 3200
`define IAP_T_WRITE0_US 2200
`define IAP_T_ERASE1_US 3700
`define IAP_T_WRITE1_US 3000
`define IAP_T_UNLOCK_US 100
`define IAP_T_READ_CYC 4
`endif

// ---- iap_pkg.sv ----
`default_nettype none
package iap_pkg;
  typedef enum logic [2:0] {
    OP_WRITE = 3'b000,
    OP_ERASE = 3'b001,
    OP_READ = 3'b011,
    OP_UNLOCK = 3'b110
  } op_sel_e;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_WIPE = 3'b001,
    ST_PROG = 3'b010,
    ST_READ = 3'b011
  } seq_state_e;
  typedef struct packed {
    logic we;
    logic [3:0] idx;
    logic [7:0] wdata;
  } sfr_req_s;
  typedef struct packed {
    logic [13:0] addr;
    logic [15:0] data;
    logic we;
    logic erase;
  } flash_cmd_s;
endpackage
`default_nettype wire

// ---- iap_flash_write_buffer_ctrl_test.sv ----
`timescale 1ns/1ps
`default_nettype none
module iap_flash_write_buffer_ctrl_test;
  // short counts so a full program cycle stays quick
  localparam int W0 = 40;
  localparam int W1 = 55;
  localparam int E0 = 70;
  logic mclk = 1'b0;
  logic sys_rst = 1'b1;
  iap_pkg::sfr_req_s sfr = '0;
  logic [3:0] ridx = 4'h0;
  logic [15:0] read_go = 16'h0000;
  logic [7:0] rdata;
  logic stall;
  logic chip_rst;
  logic busy;
  iap_pkg::flash_cmd_s fcmd;
  int err_count = 0;
  int tests_run = 0;
  int stall_cnt = 0;
  int pulses = 0;
  int mdl [13];
  int unl = 0;
  int mode = 0;
  logic [7:0] keys [6] = '{8'h00, 8'h0d, 8'hc3, 8'h04, 8'h09, 8'h40};
  int kreg [6] = '{7, 9, 11, 8, 10, 12};
  int pctl [3] = '{'h84, 'h94, 'h84};
  int ptim [3] = '{0, 0, 2};
  int pdur [3] = '{W0, E0, W1};

  always #2.5 mclk = ~mclk;

  iap_flash_write_buffer_ctrl #(.ERASE0_CYC(E0), .WRITE0_CYC(W0), .ERASE1_CYC(90), .WRITE1_CYC(W1),
    .UNLOCK_CYC(20)) u_iap_flash_write_buffer_ctrl (
    .i_mclk(mclk), .i_sys_rst(sys_rst), .i_sfr(sfr), .i_sfr_ridx(ridx), .i_flash_rdata(read_go),
    .o_sfr_rdata(rdata), .o_cpu_stall(stall), .o_chip_reset(chip_rst), .o_flash_cmd(fcmd), .o_flash_busy(busy));

  // activity counters, a stall is only legal while an accepted operation runs
  always @(posedge mclk) begin
    if (stall === 1'b1) stall_cnt++;
    if (chip_rst === 1'b1) pulses++;
  end

  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    tests_run++;
    if (g !== e) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask

  // one register write; the model follows address auto-increment itself
  task automatic wr(input int idx, input int val);
    int a;
    @(negedge mclk);
    sfr <= '{we: 1'b1, idx: idx[3:0], wdata: val[7:0]};
    @(negedge mclk);
    sfr.we <= 1'b0;
    if (idx >= 3) mdl[idx] = (idx == 4) ? (val & 'h3f) : (val & 'hff);
    if (idx == 0) begin
      unl = unl & (val >> 7);
      mode = (val >> 4) & 7;
    end
    if (idx == 6 && unl == 1 && mode < 2) begin
      a = mdl[4] * 256 + mdl[3];
      if ((a & 'h1f) != 'h1f) a++;
      mdl[3] = a & 'hff;
      mdl[4] = a >> 8;
    end
  endtask

  task automatic chk_reg(input int idx, input int e);
    @(negedge mclk);
    ridx <= idx[3:0];
    @(negedge mclk);
    chk($sformatf("register %0d", idx), e[7:0], rdata);
  endtask

  // negative index waits on the busy flag instead of a register bit
  task automatic wait_low(input int idx, input int b, input int lim, output int n);
    @(negedge mclk);
    ridx <= idx[3:0];
    @(negedge mclk);
    n = 1;
    while (((idx < 0) ? busy : rdata[b]) !== 1'b0) begin
      if (n >= lim) begin
        err_count++;
        $display("[FAIL] wait on %0d bit %0d expected 0 seen 1", idx, b);
        complete_run();
      end
      @(negedge mclk);
      n++;
    end
  endtask

  initial begin
    int n;
    int s;
    int d;
    int p;
    foreach (mdl[i]) mdl[i] = 0;
    void'($urandom(91635));
    repeat (10) @(negedge mclk);
    sys_rst <= 1'b0;
    for (int i = 0; i < 13; i++) chk_reg(i, 0);
    wr(4, 'hff);
    chk_reg(4, mdl[4]);
    wr(2, 'hfc);
    chk_reg(2, 0);
    // locked: a one in the unlocked bit and word loads do nothing
    wr(0, 'h80);
    chk_reg(0, 0);
    wr(3, 'h1d);
    wr(5, 'h12);
    wr(6, 'h34);
    chk_reg(3, mdl[3]);
    // first pass with a bad last key byte, second with the right key
    for (int pass = 0; pass < 2; pass++) begin
      wr(0, 'h60);
      wr(0, 'h68);
      for (int k = 0; k < 6; k++) wr(kreg[k], keys[k] ^ ((pass == 0 && k == 5) ? 1 : 0));
      wait_low(0, 3, 60, n);
      unl = pass;
      chk_reg(0, pass ? 'he0 : 'h60);
    end
    wr(0, 'h80);
    wr(2, 'h01);
    // busy is registered from the next state, so it rises on the same edge as the sequencer leaves idle
    @(negedge mclk);
    chk("wipe busy", 1'b1, busy);
    chk_reg(2, 1);
    wait_low(2, 0, 80, n);
    chk("wipe time", 1'b1, n >= 24 && n <= 40);
    for (int i = 0; i < 3; i++) begin
      d = $urandom;
      wr(5, d & 'hff);
      wr(6, (d >> 8) & 'hff);
      chk_reg(3, mdl[3]);
    end
    chk_reg(4, mdl[4]);
    for (int i = 0; i < 3; i++) begin
      wr(2, ptim[i]);
      s = stall_cnt;
      wr(0, pctl[i]);
      @(negedge mclk);
      chk("cmd write", i != 1, fcmd.we);
      chk("cmd erase", i == 1, fcmd.erase);
      chk("cmd addr", mdl[4] * 256 + mdl[3], fcmd.addr);
      if (i == 0) chk("cmd data", d[15:0], fcmd.data);
      wait_low(0, 2, 400, n);
      chk("op duration", 1'b1, n >= pdur[i] - 3 && n <= pdur[i] + 8);
      chk("wipe after op", 1'b1, busy);
      chk("cpu stall", 1'b1, stall_cnt > s);
      wait_low(-1, 0, 200, n);
    end
    // reserved mode codes refuse the go bit
    foreach (keys[m]) if (m == 2 || m >= 4) begin
      s = stall_cnt;
      wr(0, 'h84 | (m << 4));
      chk_reg(0, 'h80 | (m << 4));
      chk("reserved stall", s, stall_cnt);
    end
    d = $urandom & 'hffff;
    read_go <= d[15:0];
    wr(0, 'hb2);
    s = stall_cnt;
    wr(0, 'hb3);
    wait_low(0, 0, 40, n);
    mdl[5] = d & 'hff;
    mdl[6] = d >> 8;
    chk_reg(5, mdl[5]);
    chk_reg(6, mdl[6]);
    chk("read stall", 1'b1, stall_cnt > s);
    read_go <= ~d[15:0];
    s = stall_cnt;
    wr(0, 'hb1);
    chk_reg(0, 'hb0);
    chk_reg(5, mdl[5]);
    chk("no read stall", s, stall_cnt);
    // dropping the unlocked bit disables write and loads
    wr(0, 'h04);
    chk_reg(0, 0);
    chk("locked stall", s, stall_cnt);
    wr(3, 'h00);
    wr(5, 'h55);
    wr(6, 'haa);
    chk_reg(3, mdl[3]);
    p = pulses;
    wr(1, 'h54);
    wr(1, 'h55);
    repeat (3) @(negedge mclk);
    chk("chip reset pulses", p + 1, pulses);
    complete_run();
  end
endmodule
`default_nettype wire
